/* File: inc/srbu_pkg.sv */
// Constants, types and decode helpers for the upper special register bank
package srbu_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int PCH_W = 5;
  localparam int PC_W = 13;

  // Effective (bank-qualified) register addresses
  localparam logic [7:0] OFS_IND = 8'h80;
  localparam logic [7:0] OFS_OPTION = 8'h81;
  localparam logic [7:0] OFS_PC_LOW = 8'h82;
  localparam logic [7:0] OFS_STATUS = 8'h83;
  localparam logic [7:0] OFS_PTR = 8'h84;
  localparam logic [7:0] OFS_DIR_A = 8'h85;
  localparam logic [7:0] OFS_DIR_B = 8'h86;
  localparam logic [7:0] OFS_DIR_C = 8'h87;
  localparam logic [7:0] OFS_PCH = 8'h8a;
  localparam logic [7:0] OFS_IRQ_CTRL = 8'h8b;
  localparam logic [7:0] OFS_PIE = 8'h8c;
  localparam logic [7:0] OFS_PWR_CAUSE = 8'h8e;
  localparam logic [7:0] OFS_T2_PERIOD = 8'h92;
  localparam logic [7:0] OFS_SER_ADDR = 8'h93;
  localparam logic [7:0] OFS_SER_STATE = 8'h94;
  localparam logic [7:0] OFS_BANK_END = 8'h9f;

  // Implemented-bit masks; other bits read as zero
  localparam logic [7:0] MASK_DIR_A = 8'h3f;
  localparam logic [7:0] MASK_PCH = 8'h1f;
  localparam logic [7:0] MASK_PIE = 8'hcf;
  localparam logic [7:0] MASK_PWR_CAUSE = 8'h03;
  localparam logic [7:0] MASK_SER_STATE = 8'h3f;

  // Reset values
  localparam logic [7:0] RST_OPTION = 8'hff;
  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [7:0] RST_PTR = 8'h00;
  localparam logic [5:0] RST_DIR_A = 6'h3f;
  localparam logic [7:0] RST_DIR_BC = 8'hff;
  localparam logic [4:0] RST_PCH = 5'h00;
  localparam logic [7:0] RST_IRQ_CTRL = 8'h00;
  localparam logic [7:0] RST_PIE = 8'h00;
  localparam logic [1:0] RST_PWR_CAUSE = 2'h0;
  localparam logic [7:0] RST_T2_PERIOD = 8'hff;
  localparam logic [7:0] RST_SER_ADDR = 8'h00;

  // Status field positions
  localparam int ST_RP0 = 5;
  localparam int ST_TO = 4;
  localparam int ST_PD = 3;
  localparam logic [7:0] ST_SW_MASK = 8'he7;
  // Power control field positions
  localparam int PWR_ON_BIT = 1;
  localparam int PWR_BROWN_BIT = 0;

  typedef enum logic [1:0] {
    RK_RUN = 2'b00,
    RK_EXT = 2'b01,
    RK_WDT = 2'b10,
    RK_BROWN = 2'b11
  } srbu_rst_type;

  typedef enum logic [3:0] {
    SEL_NONE = 4'h0, SEL_ZERO = 4'h1, SEL_IND = 4'h2, SEL_OPTION = 4'h3,
    SEL_PC_LOW = 4'h4, SEL_STATUS = 4'h5, SEL_PTR = 4'h6, SEL_DIR_A = 4'h7,
    SEL_DIR_B = 4'h8, SEL_DIR_C = 4'h9, SEL_PCH = 4'ha, SEL_IRQ_CTRL = 4'hb,
    SEL_PIE = 4'hc, SEL_PWR_CAUSE = 4'hd, SEL_T2_PERIOD = 4'he,
    SEL_SSP = 4'hf
  } srbu_sel_type;

  // Registers mirrored in both banks
  function automatic logic srbu_is_common(input logic [6:0] a);
    return a == OFS_IND[6:0] || a == OFS_PC_LOW[6:0] || a == OFS_STATUS[6:0]
      || a == OFS_PTR[6:0] || a == OFS_PCH[6:0] || a == OFS_IRQ_CTRL[6:0];
  endfunction

  // Map a bank-qualified address to a register select
  function automatic srbu_sel_type srbu_decode(input logic [7:0] e);
    srbu_sel_type s;
    s = SEL_NONE;
    if (e == OFS_IND) s = SEL_IND;
    else if (e == OFS_OPTION) s = SEL_OPTION;
    else if (e == OFS_PC_LOW) s = SEL_PC_LOW;
    else if (e == OFS_STATUS) s = SEL_STATUS;
    else if (e == OFS_PTR) s = SEL_PTR;
    else if (e == OFS_DIR_A) s = SEL_DIR_A;
    else if (e == OFS_DIR_B) s = SEL_DIR_B;
    else if (e == OFS_DIR_C) s = SEL_DIR_C;
    else if (e == OFS_PCH) s = SEL_PCH;
    else if (e == OFS_IRQ_CTRL) s = SEL_IRQ_CTRL;
    else if (e == OFS_PIE) s = SEL_PIE;
    else if (e == OFS_PWR_CAUSE) s = SEL_PWR_CAUSE;
    else if (e == OFS_T2_PERIOD) s = SEL_T2_PERIOD;
    else if (e == OFS_SER_ADDR) s = SEL_SSP;
    else if (e == OFS_SER_STATE) s = SEL_SSP;
    else if (e >= OFS_IND && e <= OFS_BANK_END) s = SEL_ZERO;
    return s;
  endfunction

endpackage

/* File: core/srbu_reset_cause.sv */
// Reset cause classifier: syncs reset pins and ranks the causes
`timescale 1ns/1ps
module srbu_reset_cause
  import srbu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ext_reset_pin_n,
  input wire logic brownout_n,
  input wire logic wdt_timeout,
  output srbu_rst_type rst_kind
);

  typedef struct packed {
    logic ext_s1;
    logic ext_s2;
    logic brn_s1;
    logic brn_s2;
    srbu_rst_type kind;
  } srbu_rc_state_type;

  srbu_rc_state_type q, d;

  // Brown-out outranks the pin, the pin outranks the watchdog
  always_comb begin
    d = q;
    d.ext_s1 = ext_reset_pin_n;
    d.ext_s2 = q.ext_s1;
    d.brn_s1 = brownout_n;
    d.brn_s2 = q.brn_s1;
    if (!q.brn_s2) d.kind = RK_BROWN;
    else if (!q.ext_s2) d.kind = RK_EXT;
    else if (wdt_timeout) d.kind = RK_WDT;
    else d.kind = RK_RUN;
  end

  // Pins idle high, so the synchronisers reset to one
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) q <= '{1'b1, 1'b1, 1'b1, 1'b1, RK_RUN};
    else q <= d;
  end

  assign rst_kind = q.kind;

endmodule // srbu_reset_cause

/* File: core/srbu_bank.sv */
// Upper special function register bank with indirect and pc-latch logic
// Operation
// [R1] Unimplemented addresses and bits read zero
// [R2] Common registers decode alike in both banks
// [R3] Pc high only loaded through 5-bit latch
// [R4] Pin and watchdog resets load non-power values
// [R5] Unchanged bits keep; conditional bits follow cause
// [R6] Software keeps brown-out bit set on smallest part
// [R7] Software keeps indirect-bank and bank-high bits clear
// [R8] Software keeps peripheral enable/flag bits 7:6 clear
// [R9] Indirect port redirects through pointer, no storage
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module srbu_bank
  import srbu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ext_reset_pin_n,
  input wire logic brownout_n,
  input wire logic wdt_timeout,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_hit,
  output logic [DATA_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_wdata,
  output logic mem_wr,
  output logic mem_rd,
  input wire logic [DATA_W-1:0] mem_rdata,
  input wire logic [DATA_W-1:0] pc_low_in,
  output logic pc_load,
  output logic [PC_W-1:0] pc_load_addr,
  input wire logic core_flags_we,
  input wire logic [2:0] core_flags,
  input wire logic core_sleep_cmd,
  input wire logic core_clrwdt_cmd,
  input wire logic core_sleeping,
  input wire logic [2:0] irq_ctrl_events,
  input wire logic [5:0] ser_state_in,
  output logic [DATA_W-1:0] option_bits,
  output logic [DATA_W-1:0] status_bits,
  output logic [DATA_W-1:0] pointer_bits,
  output logic [5:0] port_a_dir,
  output logic [DATA_W-1:0] port_b_dir,
  output logic [DATA_W-1:0] port_c_dir,
  output logic [PCH_W-1:0] pc_high_latch,
  output logic [DATA_W-1:0] irq_ctrl_bits,
  output logic [DATA_W-1:0] irq_enable_bits,
  output logic [1:0] power_cause_bits,
  output logic [DATA_W-1:0] timer2_period,
  output logic [DATA_W-1:0] serial_addr
);

  typedef struct packed {
    logic [7:0] option;
    logic [7:0] status;
    logic [7:0] ptr;
    logic [5:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] dir_c;
    logic [4:0] pch;
    logic [7:0] irq_ctrl;
    logic [7:0] pie;
    logic [1:0] pwr_cause;
    logic [7:0] t2_period;
    logic [7:0] ser_addr;
    logic [7:0] rdata;
    logic hit;
    logic pc_load;
    logic [12:0] pc_addr;
  } srbu_state_type;

  srbu_state_type q, d;
  srbu_rst_type rst_kind;
  logic [7:0] eff;
  srbu_sel_type sel;
  logic ind_self;

  srbu_reset_cause u_cause (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ext_reset_pin_n(ext_reset_pin_n),
    .brownout_n(brownout_n),
    .wdt_timeout(wdt_timeout),
    .rst_kind(rst_kind)
  );

  // Common registers ignore the bank bit; others need bank 1
  always_comb begin
    if (srbu_is_common(reg_addr)) eff = {1'b1, reg_addr}; // [R2]
    else eff = {q.status[ST_RP0], reg_addr};
    sel = srbu_decode(eff);
  end

  // Pointer aimed at the port itself must not recurse
  assign ind_self = q.ptr[6:0] == OFS_IND[6:0];
  assign mem_addr = q.ptr; // [R9]
  assign mem_wdata = reg_wdata;
  assign mem_rd = reg_rd && sel == SEL_IND && !ind_self; // [R9]
  assign mem_wr = reg_wr && sel == SEL_IND && !ind_self
    && rst_kind == RK_RUN;

  always_comb begin
    d = q;
    d.rdata = 8'h00;
    d.hit = 1'b0;
    d.pc_load = 1'b0;

    // Read mux; answer stands only in the following cycle
    if (reg_rd) begin
      d.hit = sel != SEL_NONE;
      case (sel)
        SEL_IND: d.rdata = ind_self ? 8'h00 : mem_rdata; // [R9]
        SEL_OPTION: d.rdata = q.option;
        SEL_PC_LOW: d.rdata = pc_low_in;
        SEL_STATUS: d.rdata = q.status;
        SEL_PTR: d.rdata = q.ptr;
        SEL_DIR_A: d.rdata = {2'b00, q.dir_a}; // [R1]
        SEL_DIR_B: d.rdata = q.dir_b;
        SEL_DIR_C: d.rdata = q.dir_c;
        SEL_PCH: d.rdata = {3'b000, q.pch}; // [R1]
        SEL_IRQ_CTRL: d.rdata = q.irq_ctrl;
        SEL_PIE: d.rdata = q.pie & MASK_PIE; // [R1]
        SEL_PWR_CAUSE: d.rdata = {6'h00, q.pwr_cause}; // [R1]
        SEL_T2_PERIOD: d.rdata = q.t2_period;
        SEL_SSP: begin
          if (eff == OFS_SER_STATE) d.rdata = {2'b00, ser_state_in};
          else d.rdata = q.ser_addr;
        end
        default: d.rdata = 8'h00; // [R1]
      endcase
    end

    // Software writes; a reset in progress ignores them
    if (reg_wr && rst_kind == RK_RUN) begin
      case (sel)
        SEL_OPTION: d.option = reg_wdata;
        SEL_PC_LOW: begin
          // Counter takes latch contents as its upper bits
          d.pc_load = 1'b1;
          d.pc_addr = {q.pch, reg_wdata}; // [R3]
        end
        SEL_STATUS: begin
          // Timeout and power-down bits are not software writable
          d.status = (reg_wdata & ST_SW_MASK) | (q.status & ~ST_SW_MASK);
        end
        SEL_PTR: d.ptr = reg_wdata;
        SEL_DIR_A: d.dir_a = reg_wdata[5:0];
        SEL_DIR_B: d.dir_b = reg_wdata;
        SEL_DIR_C: d.dir_c = reg_wdata;
        SEL_PCH: d.pch = reg_wdata[4:0]; // [R3]
        SEL_IRQ_CTRL: d.irq_ctrl = reg_wdata;
        SEL_PIE: d.pie = reg_wdata & MASK_PIE; // [R8]
        SEL_PWR_CAUSE: d.pwr_cause = reg_wdata[1:0]; // [R6]
        SEL_T2_PERIOD: d.t2_period = reg_wdata;
        SEL_SSP: begin
          if (eff == OFS_SER_ADDR) d.ser_addr = reg_wdata;
        end
        default: d.pch = d.pch;
      endcase
    end

    // Core updates land after the write so arithmetic flags win
    if (core_flags_we) d.status[2:0] = core_flags;
    if (core_sleep_cmd) begin
      d.status[ST_TO] = 1'b1;
      d.status[ST_PD] = 1'b0;
    end
    if (core_clrwdt_cmd) begin
      d.status[ST_TO] = 1'b1;
      d.status[ST_PD] = 1'b1;
    end
    // Event flags: a set in the clearing cycle is kept
    d.irq_ctrl[2:0] = d.irq_ctrl[2:0] | irq_ctrl_events;

    // Reset actions by cause, applied last so they dominate
    case (rst_kind)
      RK_EXT, RK_WDT: begin
        d.option = RST_OPTION; // [R4]
        d.dir_a = RST_DIR_A;
        d.dir_b = RST_DIR_BC;
        d.dir_c = RST_DIR_BC;
        d.pch = RST_PCH;
        d.pie = RST_PIE;
        d.t2_period = RST_T2_PERIOD;
        d.ser_addr = RST_SER_ADDR;
        d.pc_load = 1'b0;
        // Bank bits clear, arithmetic flags and pointer kept
        d.status[7:5] = 3'b000; // [R5]
        d.status[2:0] = q.status[2:0]; // [R5]
        d.ptr = q.ptr; // [R5]
        d.pwr_cause = q.pwr_cause; // [R5]
        d.irq_ctrl = {7'h00, q.irq_ctrl[0]}; // [R5]
        if (rst_kind == RK_WDT) begin
          d.status[ST_TO] = 1'b0; // [R5]
          d.status[ST_PD] = !core_sleeping;
        end else if (core_sleeping) begin
          d.status[ST_TO] = 1'b1; // [R5]
          d.status[ST_PD] = 1'b0;
        end else begin
          d.status[ST_TO] = q.status[ST_TO];
          d.status[ST_PD] = q.status[ST_PD];
        end
      end
      RK_BROWN: begin
        // Brown-out looks like power-on except the cause flags
        d.option = RST_OPTION;
        d.status = RST_STATUS;
        d.ptr = RST_PTR;
        d.dir_a = RST_DIR_A;
        d.dir_b = RST_DIR_BC;
        d.dir_c = RST_DIR_BC;
        d.pch = RST_PCH;
        d.irq_ctrl = RST_IRQ_CTRL;
        d.pie = RST_PIE;
        d.t2_period = RST_T2_PERIOD;
        d.ser_addr = RST_SER_ADDR;
        d.pc_load = 1'b0;
        d.pwr_cause[PWR_BROWN_BIT] = 1'b0; // [R5]
      end
      default: d.pc_addr = d.pc_addr;
    endcase
  end

  // Power-on: unknown bits are given zero to keep simulation clean
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q <= '{RST_OPTION, RST_STATUS, RST_PTR, RST_DIR_A, RST_DIR_BC,
             RST_DIR_BC, RST_PCH, RST_IRQ_CTRL, RST_PIE, RST_PWR_CAUSE,
             RST_T2_PERIOD, RST_SER_ADDR, 8'h00, 1'b0, 1'b0, 13'h0000};
    end else begin
      q <= d;
    end
  end

  // Register outputs
  assign reg_rdata = q.rdata;
  assign reg_hit = q.hit;
  assign pc_load = q.pc_load;
  assign pc_load_addr = q.pc_addr;
  assign option_bits = q.option;
  assign status_bits = q.status;
  assign pointer_bits = q.ptr;
  assign port_a_dir = q.dir_a;
  assign port_b_dir = q.dir_b;
  assign port_c_dir = q.dir_c;
  assign pc_high_latch = q.pch;
  assign irq_ctrl_bits = q.irq_ctrl;
  assign irq_enable_bits = q.pie & MASK_PIE;
  assign power_cause_bits = q.pwr_cause;
  assign timer2_period = q.t2_period;
  assign serial_addr = q.ser_addr;

  // Helper: reads of holes inside the upper bank
  logic hole_rd;
  assign hole_rd = reg_rd && sel == SEL_ZERO;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  property p_hole_zero;
    hole_rd |=> reg_rdata == 8'h00 && reg_hit;
  endproperty
  a_hole_zero: assert property (p_hole_zero) // [R1]
    else $error("Unimplemented address did not read zero");

  property p_pie_gaps;
    reg_rd && sel == SEL_PIE |=> reg_rdata[5:4] == 2'b00;
  endproperty
  a_pie_gaps: assert property (p_pie_gaps) // [R1]
    else $error("Unimplemented enable bits read nonzero");

  property p_common;
    reg_rd && !status_bits[ST_RP0] && reg_addr == OFS_PTR[6:0]
      |=> reg_hit && reg_rdata == $past(pointer_bits);
  endproperty
  a_common: assert property (p_common) // [R2]
    else $error("Common pointer not decoded in bank 0");

  property p_pc_load;
    reg_wr && sel == SEL_PC_LOW && rst_kind == RK_RUN
      |=> pc_load && pc_load_addr == {$past(pc_high_latch),
                                      $past(reg_wdata)};
  endproperty
  a_pc_load: assert property (p_pc_load) // [R3]
    else $error("Counter load did not use latch contents");

  property p_soft_values;
    rst_kind == RK_EXT |=> option_bits == RST_OPTION
      && port_b_dir == RST_DIR_BC && pc_high_latch == RST_PCH;
  endproperty
  a_soft_values: assert property (p_soft_values) // [R4]
    else $error("Pin reset did not load reset values");

  property p_keep_ptr;
    rst_kind == RK_WDT |=> pointer_bits == $past(pointer_bits)
      && power_cause_bits == $past(power_cause_bits);
  endproperty
  a_keep_ptr: assert property (p_keep_ptr) // [R5]
    else $error("Unchanged bits altered by watchdog reset");

  property p_wdt_timeout;
    rst_kind == RK_WDT |=> !status_bits[ST_TO]
      && status_bits[7:5] == 3'b000;
  endproperty
  a_wdt_timeout: assert property (p_wdt_timeout) // [R5]
    else $error("Watchdog reset did not clear timeout bit");

  property p_redirect;
    reg_rd && sel == SEL_IND && !ind_self
      |-> mem_rd && mem_addr == pointer_bits
      ##1 reg_rdata == $past(mem_rdata);
  endproperty
  a_redirect: assert property (p_redirect) // [R9]
    else $error("Indirect read not redirected through pointer");

  c_pc_low_write: cover property (reg_wr && sel == SEL_PC_LOW ##1 pc_load);
  c_ind_read: cover property (mem_rd ##1 reg_hit);
  c_wdt_reset: cover property (rst_kind == RK_WDT ##1 rst_kind == RK_RUN);

endmodule // srbu_bank

/* File: tb/srbu_bank_test.sv */
// Self-checking bench for the upper special register bank
`timescale 1ns/1ps
module srbu_bank_test
  import srbu_pkg::*;
;

  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic ext_reset_pin_n = 1'b1;
  logic brownout_n = 1'b1;
  logic wdt_timeout = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 7'h00;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata, mem_addr, mem_wdata, mem_rdata;
  logic reg_hit, mem_wr, mem_rd, pc_load;
  logic [PC_W-1:0] pc_load_addr;
  logic core_flags_we = 1'b0;
  logic [2:0] core_flags = 3'h0;
  logic core_sleep_cmd = 1'b0;
  logic core_clrwdt_cmd = 1'b0;
  logic core_sleeping = 1'b0;
  logic [2:0] irq_ctrl_events = 3'h0;
  logic [DATA_W-1:0] opt_o, st_o, ptr_o, dirb_o, dirc_o, ic_o, pie_o, pr2_o;
  logic [DATA_W-1:0] sa_o;
  logic [5:0] dira_o;
  logic [PCH_W-1:0] pch_o;
  logic [1:0] power_reset_cause_o;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Reset-value table of the bank, seen with bank 1 selected
  logic [6:0] ra [22] = '{7'h01, 7'h02, 7'h04, 7'h05, 7'h06, 7'h07, 7'h0a,
    7'h0b, 7'h0c, 7'h0e, 7'h12, 7'h13, 7'h14, 7'h08, 7'h09, 7'h0d, 7'h0f,
    7'h10, 7'h11, 7'h15, 7'h1f, 7'h00};
  logic [7:0] rv [22] = '{8'hff, 8'h5a, 8'h00, 8'h3f, 8'hff, 8'hff, 8'h00,
    8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h2a, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // Data memory stand-in; off-cycle it shows a moving pattern, not stale data
  assign mem_rdata = mem_rd ? (mem_addr ^ 8'h32) : cyc[7:0];

  always #12.5 clk_sys = ~clk_sys;

  srbu_bank u_srbu_bank (.clk_sys(clk_sys), .resetn(resetn),
    .ext_reset_pin_n(ext_reset_pin_n), .brownout_n(brownout_n),
    .wdt_timeout(wdt_timeout), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .pc_low_in(8'h5a), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
    .core_flags_we(core_flags_we), .core_flags(core_flags),
    .core_sleep_cmd(core_sleep_cmd), .core_clrwdt_cmd(core_clrwdt_cmd),
    .core_sleeping(core_sleeping), .irq_ctrl_events(irq_ctrl_events),
    .ser_state_in(6'h2a), .option_bits(opt_o), .status_bits(st_o),
    .pointer_bits(ptr_o), .port_a_dir(dira_o), .port_b_dir(dirb_o),
    .port_c_dir(dirc_o), .pc_high_latch(pch_o), .irq_ctrl_bits(ic_o),
    .irq_enable_bits(pie_o), .power_cause_bits(power_reset_cause_o),
    .timer2_period(pr2_o), .serial_addr(sa_o));

  // Compare one value; a wide vector covers the 13-bit load address
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data and hit are valid only in the cycle after the strobe
  task automatic rd(input logic [6:0] a, input logic [7:0] e, input logic h);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
    chk(reg_hit, h);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard, generous against roughly 160 cycles of tests
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    cycles(2);
    resetn <= 1'b1;
    // Bank 0 sees only the common registers
    rd(7'h05, 8'h00, 1'b0);
    rd(7'h04, 8'h00, 1'b1);
    rd(7'h03, 8'h18, 1'b1);
    wr(7'h03, 8'h20);
    rd(7'h03, 8'h38, 1'b1);
    for (int i = 0; i < 22; i++) rd(ra[i], rv[i], 1'b1);
    $display("test reset values done");

    // Unimplemented bits read zero; read-only and empty places ignore writes
    wr(7'h05, 8'hff);
    rd(7'h05, 8'h3f, 1'b1);
    wr(7'h0a, 8'hff);
    rd(7'h0a, 8'h1f, 1'b1);
    wr(7'h0e, 8'hff);
    rd(7'h0e, 8'h03, 1'b1);
    wr(7'h0c, 8'h0f);
    rd(7'h0c, 8'h0f, 1'b1);
    wr(7'h14, 8'hff);
    rd(7'h14, 8'h2a, 1'b1);
    wr(7'h08, 8'hff);
    rd(7'h08, 8'h00, 1'b1);
    chk(sa_o, 8'h00);
    $display("test masks done");

    // Upper pc bits only move through the latch on a low-byte write
    wr(7'h0a, 8'h15);
    wr(7'h02, 8'h34);
    #1;
    chk(pc_load, 1'b1);
    chk(pc_load_addr, 16'h1534);
    @(posedge clk_sys);
    #1;
    chk(pc_load, 1'b0);
    rd(7'h0a, 8'h15, 1'b1);
    $display("test pc latch done");

    // Indirect port goes through the pointer and stores nothing
    wr(7'h04, 8'h45);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= 7'h00;
    #1;
    chk(mem_rd, 1'b1);
    chk(mem_addr, 8'h45);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, 8'h77);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_wdata <= 8'h99;
    #1;
    chk({mem_wr, mem_wdata}, 16'h0199);
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    wr(7'h04, 8'h80);
    rd(7'h00, 8'h00, 1'b1);
    $display("test indirect done");

    // Watchdog reset with the core awake
    wr(7'h03, 8'h27);
    wr(7'h01, 8'h12);
    wr(7'h04, 8'h45);
    wr(7'h0b, 8'h81);
    wr(7'h0a, 8'h15);
    wr(7'h0e, 8'h03);
    wr(7'h12, 8'h10);
    wr(7'h05, 8'h15);
    wr(7'h06, 8'ha5);
    wr(7'h07, 8'h3c);
    wr(7'h13, 8'h66);
    rd(7'h13, 8'h66, 1'b1);
    chk({opt_o, pr2_o}, 16'h1210);
    chk({dirb_o, dirc_o}, 16'ha53c);
    chk({sa_o, pie_o}, 16'h660f);
    chk({2'h0, dira_o}, 16'h0015);
    chk(st_o, 8'h3f);
    @(posedge clk_sys);
    wdt_timeout <= 1'b1;
    @(posedge clk_sys);
    wdt_timeout <= 1'b0;
    cycles(4);
    #1;
    chk({opt_o, st_o}, 16'hff0f);
    chk({ptr_o, ic_o}, 16'h4501);
    chk({3'h0, pch_o, 6'h0, power_reset_cause_o}, 16'h0003);
    chk(pr2_o, 8'hff);
    chk({dirb_o, dirc_o}, 16'hffff);
    chk({sa_o, pie_o}, 16'h0000);
    chk({2'h0, dira_o}, 16'h003f);
    $display("test watchdog reset done");

    // Pin reset while asleep; writes during it are dropped
    @(posedge clk_sys);
    core_sleeping <= 1'b1;
    ext_reset_pin_n <= 1'b0;
    cycles(5);
    wr(7'h0a, 8'h07);
    ext_reset_pin_n <= 1'b1;
    cycles(6);
    #1;
    chk({st_o, ic_o}, 16'h1701);
    chk({3'h0, pch_o, ptr_o}, 16'h0045);
    @(posedge clk_sys);
    core_sleeping <= 1'b0;
    core_clrwdt_cmd <= 1'b1;
    @(posedge clk_sys);
    core_clrwdt_cmd <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(st_o, 8'h1f);
    @(posedge clk_sys);
    core_sleep_cmd <= 1'b1;
    @(posedge clk_sys);
    core_sleep_cmd <= 1'b0;
    core_flags_we <= 1'b1;
    core_flags <= 3'h2;
    irq_ctrl_events <= 3'h6;
    @(posedge clk_sys);
    core_flags_we <= 1'b0;
    irq_ctrl_events <= 3'h0;
    @(posedge clk_sys);
    #1;
    chk({st_o, ic_o}, 16'h1207);
    $display("test pin reset done");

    // Brown-out keeps the power-on flag and clears the brown-out flag
    @(posedge clk_sys);
    brownout_n <= 1'b0;
    cycles(6);
    brownout_n <= 1'b1;
    cycles(6);
    #1;
    chk({6'h0, power_reset_cause_o}, 16'h0002);
    chk({st_o, ptr_o}, 16'h1800);
    chk({opt_o, ic_o}, 16'hff00);
    $display("test brown-out reset done");
    end_of_test();
  end

endmodule // srbu_bank_test
